// *** rtl/fcs_defines.vh ***
// Constants for the flash command sequencer: offsets, fields, resets, timing
`ifndef FCS_DEFINES_VH
`define FCS_DEFINES_VH

// Register indexes; the byte address is four times the index
`define FCS_IDX_CLKDIV      14'h1820
`define FCS_IDX_OPTIONS     14'h1821
`define FCS_IDX_CONFIG      14'h1823
`define FCS_IDX_PROTECT     14'h1824
`define FCS_IDX_STATUS      14'h1825
`define FCS_IDX_COMMAND     14'h1826
`define FCS_IDX_ARRAY_ADDR  14'h1828
`define FCS_IDX_ARRAY_DATA  14'h1829
`define FCS_IDX_IRQ_STATUS  14'h182a
`define FCS_IDX_IRQ_MASK    14'h182b

// Status register fields
`define FCS_ST_CBEF         7
`define FCS_ST_CCF          6
`define FCS_ST_PVIOL        5
`define FCS_ST_ACCERR       4
`define FCS_ST_BLANK        2

// Clock divider loaded flag and configuration key bit
`define FCS_DIV_LOADED      7
`define FCS_CFG_KEYACC      5

// Interrupt status fields
`define FCS_IRQ_DONE        0
`define FCS_IRQ_ACCERR      1
`define FCS_IRQ_PVIOL       2

// Reset values
`define FCS_RST_CLKDIV      8'h00
`define FCS_RST_OPTIONS     8'h02
`define FCS_RST_CONFIG      8'h01
`define FCS_RST_STATUS      8'hc0
`define FCS_RST_MASK        3'h0

// Command codes
`define FCS_CMD_BLANK       8'h05
`define FCS_CMD_PROG        8'h20
`define FCS_CMD_BURST       8'h25
`define FCS_CMD_SECTOR      8'h40
`define FCS_CMD_MASS        8'h41

// Protection: all ones protects nothing, each step is 1.5K from the top
`define FCS_FPS_NONE        6'h3f
`define FCS_FPS_STEP        17'h00600
`define FCS_MEM_TOP         17'h10000

// Times in ns and the core clock in MHz
`define FCS_CLK_MHZ         250
`define FCS_T_PROG_NS       8000
`define FCS_T_BURST_NS      5000
`define FCS_T_BLANK_NS      2000
`define FCS_T_HV_NS         400
`define FCS_T_ERASE_NS      80000
`define FCS_CYC_PROG        ((`FCS_T_PROG_NS * `FCS_CLK_MHZ) / 1000)
`define FCS_CYC_BURST       ((`FCS_T_BURST_NS * `FCS_CLK_MHZ) / 1000)
`define FCS_CYC_BLANK       ((`FCS_T_BLANK_NS * `FCS_CLK_MHZ) / 1000)
`define FCS_CYC_HV          ((`FCS_T_HV_NS * `FCS_CLK_MHZ) / 1000)
`define FCS_CYC_ERASE       ((`FCS_T_ERASE_NS * `FCS_CLK_MHZ) / 1000)
`define FCS_TMR_W           20

`endif

// *** rtl/fcs_timer.v ***
// Down counter that flags the end of a loaded interval
`timescale 1ns/1ps
`default_nettype none
module fcs_timer #(
    parameter W = 20
) (
    input  wire         core_clk,
    input  wire         rst,
    input  wire         load,
    input  wire [W-1:0] load_val,
    output reg          done
);
    reg [W-1:0] count;
    reg         running;

    // Count down from the loaded value, one-cycle done at the end
    // The load strobe and the done flag are both registered, so done
    // rises three counts early and the interval seen outside is exact
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count   <= {W{1'b0}};
            running <= 1'b0;
            done    <= 1'b0;
        end else if (load) begin
            count   <= load_val;
            running <= 1'b1;
            done    <= 1'b0;
        end else if (running && count <= {{(W-2){1'b0}}, 2'b11}) begin
            running <= 1'b0;
            done    <= 1'b1;
        end else begin
            count   <= running ? count - {{(W-1){1'b0}}, 1'b1} : count;
            done    <= 1'b0;
        end
    end
endmodule // fcs_timer
`default_nettype wire

// *** rtl/fcs_top.v ***
// Flash command sequencer with Avalon-MM register slave
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"
module fcs_top #(
    parameter CYC_ERASE = `FCS_CYC_ERASE
) (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [15:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire [7:0]  nonvolatile_protect_byte,
    input  wire        array_blank,
    output reg         irq,
    output reg         pump_on,
    output reg         array_program,
    output reg         array_erase,
    output reg         array_mass,
    output reg         array_verify,
    output reg  [15:0] array_addr,
    output reg  [7:0]  array_wdata
);
    // Sequence states
    localparam [2:0] S_EMPTY = 3'b001;
    localparam [2:0] S_ARRAY = 3'b010;
    localparam [2:0] S_CMD   = 3'b100;
    // Execution states
    localparam [3:0] E_IDLE = 4'b0001;
    localparam [3:0] E_RAMP = 4'b0010;
    localparam [3:0] E_RUN  = 4'b0100;
    localparam [3:0] E_DOWN = 4'b1000;

    localparam [`FCS_TMR_W-1:0] T_PROG  = `FCS_CYC_PROG;
    localparam [`FCS_TMR_W-1:0] T_BURST = `FCS_CYC_BURST;
    localparam [`FCS_TMR_W-1:0] T_BLANK = `FCS_CYC_BLANK;
    localparam [`FCS_TMR_W-1:0] T_HV    = `FCS_CYC_HV;
    localparam [`FCS_TMR_W-1:0] T_ERASE = CYC_ERASE[`FCS_TMR_W-1:0];

    // Register state
    reg [7:0]  flash_clock_divider;
    reg        keyacc;
    reg [5:0]  protect_select_field;
    reg        prot_loaded;
    reg        cmd_buffer_empty_flag;
    reg        cmd_complete_flag;
    reg        protection_violation_flag;
    reg        access_error_flag;
    reg        blank_check_flag;
    reg [7:0]  flash_command;
    reg [15:0] pend_addr;
    reg [2:0]  irq_status;
    reg [2:0]  irq_mask;
    reg        ccf_d;
    // Sequence and command buffer
    reg [2:0]  seq;
    reg        buf_valid;
    reg [15:0] buf_addr;
    reg [7:0]  buf_data;
    reg [7:0]  buf_cmd;
    // Executing command
    reg [3:0]  ex;
    reg [15:0] cur_addr;
    reg [7:0]  cur_cmd;
    reg        tmr_load;
    reg [`FCS_TMR_W-1:0] tmr_val;
    wire       tmr_done;
    reg [31:0] rd_mux;

    // Bus handshake: a request is served at the edge where waitrequest is seen low
    wire        bus_act = (avs_read | avs_write) & ~avs_waitrequest;
    wire        wr_go   = avs_write & ~avs_waitrequest;
    wire        rd_go   = avs_read & ~avs_waitrequest;
    wire        word_ok = (avs_address[1:0] == 2'b00);
    wire [13:0] idx     = avs_address[15:2];
    wire [7:0]  wd      = avs_writedata[7:0];

    // Protected region start, from the top of memory downwards
    wire [16:0] prot_size = {11'h000, `FCS_FPS_NONE - protect_select_field} * `FCS_FPS_STEP;
    wire        buf_is_pe = (buf_cmd != `FCS_CMD_BLANK);
    wire        buf_prot  = (protect_select_field != `FCS_FPS_NONE) &&
                            ((buf_cmd == `FCS_CMD_MASS) || (prot_size >= `FCS_MEM_TOP) ||
                             ({1'b0, buf_addr} >= (`FCS_MEM_TOP - prot_size)));

    wire        cmd_known = (wd == `FCS_CMD_BLANK) || (wd == `FCS_CMD_PROG) ||
                            (wd == `FCS_CMD_BURST) || (wd == `FCS_CMD_SECTOR) ||
                            (wd == `FCS_CMD_MASS);

    // Bus-side sequence events
    wire w_data   = wr_go & word_ok & (idx == `FCS_IDX_ARRAY_DATA);
    wire w_cmd    = wr_go & word_ok & (idx == `FCS_IDX_COMMAND);
    wire w_stat   = wr_go & word_ok & (idx == `FCS_IDX_STATUS);
    wire seq_ok   = ~access_error_flag & ~protection_violation_flag;
    wire arr_ok   = w_data & seq_ok & (seq == S_EMPTY) & cmd_buffer_empty_flag &
                    flash_clock_divider[`FCS_DIV_LOADED];
    wire arr_bad  = w_data & ~arr_ok & seq_ok;
    wire cmd_ok   = w_cmd & (seq == S_ARRAY) & cmd_known;
    wire cmd_bad  = w_cmd & ~cmd_ok & seq_ok;
    wire st_go    = w_stat & wd[`FCS_ST_CBEF];
    wire launch_try = st_go & (seq == S_CMD);
    wire viol_now = launch_try & buf_is_pe & buf_prot;
    wire launch   = launch_try & ~viol_now;
    wire abort    = w_stat & ~wd[`FCS_ST_CBEF] & (seq != S_EMPTY);
    wire go_bad   = st_go & (seq == S_ARRAY);
    wire acc_set  = arr_bad | cmd_bad | abort | go_bad;

    // Chaining test for burst: queued burst, next address, same 32-byte block
    wire [15:0] next_addr = cur_addr + 16'h0001;
    wire chain_ok = (cur_cmd == `FCS_CMD_BURST) && buf_valid &&
                    (buf_cmd == `FCS_CMD_BURST) && (buf_addr == next_addr) &&
                    (buf_addr[15:5] == cur_addr[15:5]);
    wire take_now = ((ex == E_IDLE) & buf_valid) | ((ex == E_RUN) & tmr_done & chain_ok);

    fcs_timer #(
        .W        (`FCS_TMR_W)
    ) u_timer (
        .core_clk (core_clk),
        .rst      (rst),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // Avalon slave: one wait cycle, read data registered with it
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else if (bus_act) begin
            avs_waitrequest <= 1'b1;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : 32'h0000_0000;
        end
    end

    // Read multiplexer, unmapped addresses read as zero
    always @* begin
        rd_mux = 32'h0000_0000;
        if (word_ok) begin
            case (idx)
                `FCS_IDX_CLKDIV:     rd_mux[7:0] = flash_clock_divider;
                `FCS_IDX_OPTIONS:    rd_mux[7:0] = `FCS_RST_OPTIONS;
                `FCS_IDX_CONFIG:     rd_mux[7:0] = {2'b00, keyacc, 5'h01};
                `FCS_IDX_PROTECT:    rd_mux[7:0] = {2'b00, protect_select_field};
                `FCS_IDX_STATUS:     rd_mux[7:0] = {cmd_buffer_empty_flag, cmd_complete_flag,
                                                    protection_violation_flag,
                                                    access_error_flag, 1'b0,
                                                    blank_check_flag, 2'b00};
                `FCS_IDX_COMMAND:    rd_mux[7:0] = flash_command;
                `FCS_IDX_ARRAY_ADDR: rd_mux[15:0] = pend_addr;
                `FCS_IDX_ARRAY_DATA: rd_mux[7:0] = buf_data;
                `FCS_IDX_IRQ_STATUS: rd_mux[2:0] = irq_status;
                `FCS_IDX_IRQ_MASK:   rd_mux[2:0] = irq_mask;
                default:             rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Plain control registers and protection load after reset release
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            flash_clock_divider  <= `FCS_RST_CLKDIV;
            keyacc               <= 1'b0;
            protect_select_field <= `FCS_FPS_NONE;
            prot_loaded          <= 1'b0;
            pend_addr            <= 16'h0000;
            irq_mask             <= `FCS_RST_MASK;
        end else begin
            if (!prot_loaded) begin
                protect_select_field <= nonvolatile_protect_byte[5:0];
                prot_loaded          <= 1'b1;
            end else if (wr_go && word_ok && idx == `FCS_IDX_PROTECT) begin
                protect_select_field <= wd[5:0];
            end
            if (wr_go && word_ok && idx == `FCS_IDX_CLKDIV)
                flash_clock_divider <= {1'b1, wd[6:0]};
            if (wr_go && word_ok && idx == `FCS_IDX_CONFIG)
                keyacc <= wd[`FCS_CFG_KEYACC];
            if (wr_go && word_ok && idx == `FCS_IDX_ARRAY_ADDR && seq == S_EMPTY)
                pend_addr <= avs_writedata[15:0];
            if (wr_go && word_ok && idx == `FCS_IDX_IRQ_MASK)
                irq_mask <= avs_writedata[2:0];
        end
    end

    // Sequence checker, command buffer and status flags
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            seq                       <= S_EMPTY;
            buf_valid                 <= 1'b0;
            buf_addr                  <= 16'h0000;
            buf_data                  <= 8'h00;
            buf_cmd                   <= 8'h00;
            flash_command             <= 8'h00;
            cmd_buffer_empty_flag     <= 1'b1;
            protection_violation_flag <= 1'b0;
            access_error_flag         <= 1'b0;
        end else begin
            // Array write opens a sequence
            if (arr_ok) begin
                buf_addr <= pend_addr;
                buf_data <= wd;
                seq      <= S_ARRAY;
            end
            if (cmd_ok) begin
                flash_command <= wd;
                buf_cmd       <= wd;
                seq           <= S_CMD;
            end
            if (launch) begin
                buf_valid             <= 1'b1;
                cmd_buffer_empty_flag <= 1'b0;
                seq                   <= S_EMPTY;
            end else if (take_now) begin
                buf_valid             <= 1'b0;
                cmd_buffer_empty_flag <= 1'b1;
            end
            // Errors discard the partial sequence
            if (acc_set || viol_now)
                seq <= S_EMPTY;
            // Write one clears, a new event wins over the clear
            if (acc_set)
                access_error_flag <= 1'b1;
            else if (w_stat && wd[`FCS_ST_ACCERR])
                access_error_flag <= 1'b0;
            if (viol_now)
                protection_violation_flag <= 1'b1;
            else if (w_stat && wd[`FCS_ST_PVIOL])
                protection_violation_flag <= 1'b0;
        end
    end

    // Executor: pump ramp, array operation, burst chaining, pump shutdown
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ex                <= E_IDLE;
            cur_addr          <= 16'h0000;
            cur_cmd           <= 8'h00;
            cmd_complete_flag <= 1'b1;
            blank_check_flag  <= 1'b0;
            pump_on           <= 1'b0;
            array_program     <= 1'b0;
            array_erase       <= 1'b0;
            array_mass        <= 1'b0;
            array_verify      <= 1'b0;
            array_addr        <= 16'h0000;
            array_wdata       <= 8'h00;
            tmr_load          <= 1'b0;
            tmr_val           <= {`FCS_TMR_W{1'b0}};
        end else begin
            tmr_load <= 1'b0;
            if (launch)
                cmd_complete_flag <= 1'b0;
            case (ex)
                E_IDLE: begin
                    if (buf_valid) begin
                        cur_addr         <= buf_addr;
                        cur_cmd          <= buf_cmd;
                        array_addr       <= buf_addr;
                        array_wdata      <= buf_data;
                        blank_check_flag <= 1'b0;
                        tmr_load         <= 1'b1;
                        if (buf_cmd == `FCS_CMD_BLANK) begin
                            array_verify <= 1'b1;
                            tmr_val      <= T_BLANK;
                            ex           <= E_RUN;
                        end else begin
                            pump_on <= 1'b1;
                            tmr_val <= T_HV;
                            ex      <= E_RAMP;
                        end
                    end else if (!launch) begin
                        cmd_complete_flag <= 1'b1;
                    end
                end
                E_RAMP: begin
                    if (tmr_done) begin
                        tmr_load <= 1'b1;
                        ex       <= E_RUN;
                        if (cur_cmd == `FCS_CMD_SECTOR || cur_cmd == `FCS_CMD_MASS) begin
                            array_erase <= 1'b1;
                            array_mass  <= (cur_cmd == `FCS_CMD_MASS);
                            tmr_val     <= T_ERASE;
                        end else begin
                            array_program <= 1'b1;
                            tmr_val       <= T_PROG;
                        end
                    end
                end
                E_RUN: begin
                    if (tmr_done) begin
                        array_program <= 1'b0;
                        array_erase   <= 1'b0;
                        array_mass    <= 1'b0;
                        array_verify  <= 1'b0;
                        if (cur_cmd == `FCS_CMD_BLANK) begin
                            blank_check_flag <= array_blank;
                            ex               <= E_IDLE;
                        end else if (chain_ok) begin
                            cur_addr      <= buf_addr;
                            array_addr    <= buf_addr;
                            array_wdata   <= buf_data;
                            array_program <= 1'b1;
                            tmr_load      <= 1'b1;
                            tmr_val       <= T_BURST;
                        end else begin
                            pump_on  <= 1'b0;
                            tmr_load <= 1'b1;
                            tmr_val  <= T_HV;
                            ex       <= E_DOWN;
                        end
                    end
                end
                E_DOWN: begin
                    if (tmr_done)
                        ex <= E_IDLE;
                end
                default: ex <= E_IDLE;
            endcase
        end
    end

    // Interrupt status: sticky events, cleared by reading, event wins
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            irq_status <= 3'h0;
            ccf_d      <= 1'b1;
            irq        <= 1'b0;
        end else begin
            ccf_d <= cmd_complete_flag;
            irq_status <= (rd_go && word_ok && idx == `FCS_IDX_IRQ_STATUS ? 3'h0 : irq_status) |
                          {viol_now, acc_set, cmd_complete_flag & ~ccf_d};
            irq <= |(irq_status & irq_mask);
        end
    end
endmodule // fcs_top
`default_nettype wire

// *** sim/fcs_top_sva.sv ***
// Port checker for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
module fcs_checker (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        avs_waitrequest,
    input wire logic        pump_on,
    input wire logic        array_program,
    input wire logic        array_erase,
    input wire logic        array_mass,
    input wire logic        array_verify,
    input wire logic [15:0] array_addr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Bus answer and array strobe relations
    a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_prog_pump: assert property (array_program |-> pump_on)
        else $error("program without pump");
    a_erase_pump: assert property (array_erase |-> pump_on)
        else $error("erase without pump");
    a_pump_ramp: assert property ($rose(array_program) |-> $past(pump_on, 2))
        else $error("program before pump ramp");
    a_mass_erase: assert property (array_mass |-> array_erase)
        else $error("mass without erase");
    a_blank_cold: assert property (array_verify |-> !pump_on)
        else $error("pump on in blank check");
    a_one_op: assert property ($onehot0({array_program, array_erase, array_verify}))
        else $error("two array operations");
    a_addr_hold: assert property (array_program && $past(array_program) && !$stable(array_addr)
        |-> array_addr == $past(array_addr) + 16'h0001)
        else $error("address jumped in program");
    a_pump_drop: assert property ($fell(pump_on) |-> !array_program && !array_erase)
        else $error("pump dropped mid operation");
endmodule // fcs_checker
bind fcs_top fcs_checker u_chk (.core_clk(core_clk), .rst(rst),
    .avs_waitrequest(avs_waitrequest), .pump_on(pump_on), .array_program(array_program),
    .array_erase(array_erase), .array_mass(array_mass), .array_verify(array_verify),
    .array_addr(array_addr));
`default_nettype wire

// *** sim/tb_flash_command_sequencer.sv ***
// Self-checking bench for the flash command sequencer
`timescale 1ns/1ps
`default_nettype none
`include "fcs_defines.vh"
module tb_flash_command_sequencer;
    localparam logic [13:0] ST = `FCS_IDX_STATUS;
    localparam logic [13:0] IS = `FCS_IDX_IRQ_STATUS;
    logic        core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, blank = 1'b0;
    logic [15:0] avs_address = 16'h0, a, pa;
    logic [31:0] avs_writedata = 32'h0, q;
    logic [7:0]  nv = 8'h0, d, pw, c;
    logic [5:0]  f;
    wire  [31:0] rdata;
    wire  [15:0] aa;
    wire  [7:0]  aw;
    wire         wreq, irq, pump, prog, ers, mass, ver;
    int          n_errors = 0, checks = 0, cyc = 0, plen = 0;
    int          len_q[$], drop_q[$];
    bit          pdrop = 1'b1;
    logic [7:0]  cmd_codes[4] = '{8'h20, 8'h05, 8'h40, 8'h41};
    int          blens[3] = '{`FCS_CYC_PROG, `FCS_CYC_BURST, `FCS_CYC_PROG};
    logic [5:0]  fsel[4] = '{6'h1f, 6'h1f, 6'h3e, 6'h3e};
    logic [15:0] fadr[4] = '{16'h4000, 16'h3fff, 16'hfa00, 16'hf9ff};
    always #2 core_clk = ~core_clk;
    fcs_top #(.CYC_ERASE(20)) u_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(rdata), .avs_waitrequest(wreq), .nonvolatile_protect_byte(nv),
        .array_blank(blank), .irq(irq), .pump_on(pump), .array_program(prog),
        .array_erase(ers), .array_mass(mass), .array_verify(ver), .array_addr(aa),
        .array_wdata(aw));
    // Timeout, program pulse lengths and pump drops before each pulse
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc > 60000) begin
            n_errors++;
            conclude();
        end
        if (!pump) pdrop <= 1'b1;
        // A chained burst byte keeps the strobe up; a new address opens a new pulse
        if (prog && (plen == 0 || aa != pa)) begin
            if (plen != 0) len_q.push_back(plen);
            drop_q.push_back(pdrop);
            pdrop <= 1'b0;
            pa <= aa;
            pw <= aw;
            plen <= 1;
        end else if (prog) plen <= plen + 1;
        else if (plen != 0) begin
            len_q.push_back(plen);
            plen <= 0;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic bus(input bit wr, input logic [13:0] idx, input logic [15:0] dv);
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0, dv};
        do @(posedge core_clk); while (wreq !== 1'b0);
        q = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [13:0] i, input logic [31:0] e, m);
        bus(0, i, 16'h0);
        chk(nm, e, q & m);
    endtask
    task automatic cmd(input logic [15:0] ad, input logic [7:0] dd, cc);
        bus(1, `FCS_IDX_ARRAY_ADDR, ad);
        bus(1, `FCS_IDX_ARRAY_DATA, {8'h0, dd});
        bus(1, `FCS_IDX_COMMAND, {8'h0, cc});
        bus(1, ST, 16'h80);
    endtask
    task automatic poll(input int b);
        do bus(0, ST, 16'h0); while (q[b] !== 1'b1);
    endtask
    function automatic bit prot(input logic [5:0] fs, input logic [15:0] ad);
        if (fs == 6'h3f) return 1'b0;
        if (fs < 6'h1f) return 1'b1;
        return int'(ad) >= 32'h10000 - (32'h3f - int'(fs)) * 32'h600;
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'hc85b));
        nv <= $urandom;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        repeat (2) @(posedge core_clk);
        rdc("status", ST, 32'hc0, 32'hff);
        rdc("options", `FCS_IDX_OPTIONS, 32'h02, 32'hff);
        rdc("protect", `FCS_IDX_PROTECT, {26'h0, nv[5:0]}, 32'h3f);
        rdc("unmapped", 14'h1822, 32'h0, 32'hffffffff);
        d = $urandom;
        bus(1, `FCS_IDX_CLKDIV, {8'h0, d});
        rdc("divider", `FCS_IDX_CLKDIV, {24'h1, d[6:0]} | 32'h80, 32'hff);
        bus(1, `FCS_IDX_IRQ_MASK, 16'h7);
        bus(1, `FCS_IDX_PROTECT, 16'h3f);
        $display("test reset done");
        // Every command code except burst once, with completion and interrupt
        foreach (cmd_codes[i]) begin
            c = cmd_codes[i];
            a = $urandom;
            d = $urandom;
            blank <= $urandom;
            len_q.delete();
            cmd(a, d, c);
            poll(6);
            chk("done", {24'h0, c == 8'h05 ? 8'hc0 | {5'h0, blank, 2'h0} : 8'hc0},
                q & (c == 8'h05 ? 32'hff : 32'hf0));
            if (c == 8'h20) begin
                chk("addr", {16'h0, a}, {16'h0, pa});
                chk("wdata", {24'h0, d}, {24'h0, pw});
                chk("ptime", `FCS_CYC_PROG, len_q[0]);
            end
            chk("pump", 32'h0, {31'h0, pump});
            repeat (2) @(posedge core_clk);
            chk("irq", 32'h1, {31'h0, irq});
            rdc("irq_status", IS, 32'h1, 32'h7);
            repeat (2) @(posedge core_clk);
            chk("irq_clr", 32'h0, {31'h0, irq});
        end
        $display("test commands done");
        // Three burst bytes, the second chained, the last one entering a new block and not chained
        a = {1'b0, 10'($urandom), 5'h1e};
        len_q.delete();
        drop_q.delete();
        for (int i = 0; i < 3; i++) begin
            poll(7);
            cmd(a + i, $urandom, `FCS_CMD_BURST);
        end
        poll(6);
        repeat (3) @(posedge core_clk);
        chk("pump_end", 32'h0, {31'h0, pump});
        foreach (blens[i]) begin
            chk("blen", blens[i], len_q[i]);
            chk("bdrop", i != 1, drop_q[i]);
        end
        rdc("irq_status", IS, 32'h1, 32'h7);
        $display("test burst done");
        // Abort and out-of-order steps with only completion unmasked
        bus(1, `FCS_IDX_IRQ_MASK, 16'h1);
        bus(1, `FCS_IDX_ARRAY_DATA, 16'h5a);
        bus(1, ST, 16'h0);
        rdc("abort", ST, 32'h90, 32'h90);
        chk("irq_mask", 32'h0, {31'h0, irq});
        bus(1, ST, 16'h30);
        bus(1, `FCS_IDX_COMMAND, 16'h20);
        rdc("order", ST, 32'h90, 32'h90);
        bus(1, ST, 16'h30);
        rdc("irq_acc", IS, 32'h2, 32'h7);
        $display("test abort done");
        // Protection boundaries, then random selections
        for (int i = 0; i < 6; i++) begin
            f = i < 4 ? fsel[i] : 6'h1f + $urandom % 32;
            a = i < 4 ? fadr[i] : 16'($urandom);
            bus(1, `FCS_IDX_PROTECT, {10'h0, f});
            cmd(a, 8'h3c, `FCS_CMD_PROG);
            if (prot(f, a)) rdc("pviol", ST, 32'ha0, 32'ha0);
            else begin
                poll(6);
                chk("unprot", 32'hc0, q & 32'hf0);
            end
            bus(1, ST, 16'h30);
        end
        $display("test protect done");
        conclude();
    end
endmodule // tb_flash_command_sequencer
`default_nettype wire
